// File: rtl/bvs_pkg.sv
// constants for the bus voltage supervisor and group fault logic
package bvs_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] LOW_THR_OFS = 8'h04;
    localparam logic [7:0] HIGH_THR_OFS = 8'h08;
    localparam logic [7:0] LEVEL_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] PROG_OFS = 8'h14;
    localparam logic [7:0] PROP_OFS = 8'h18;
    localparam logic [7:0] AUX_OFS = 8'h1c;
    // control fields
    localparam int CTRL_AUTO_ON = 0;
    localparam int CTRL_REF_EXT = 1;
    localparam int CTRL_TURN_ON = 2;
    // status fields
    localparam int ST_BUS_LOW = 0;
    localparam int ST_BUS_HIGH = 1;
    localparam int ST_REF_ACT = 2;
    localparam int ST_FRONT_END_ENABLE = 3;
    localparam int ST_CROWBAR = 4;
    localparam int ST_OK_LSB = 8;
    localparam int ST_AUX_LSB = 12;
    localparam int ST_STATE_LSB = 16;
    // propagation fields
    localparam int PROP_ERR_FE_LSB = 16;
    localparam int PROP_ERR_CB_LSB = 20;
    // aux fields
    localparam int AUX_BLK_LSB = 4;
    localparam int AUX_GRP_LSB = 8;
    // reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [9:0] LOW_THR_RST = 10'h000;
    localparam logic [9:0] HIGH_THR_RST = 10'h3ff;
    localparam logic [23:0] PROP_RST = 24'h00_0000;
    localparam logic [15:0] AUX_RST = 16'h0000;
    // timing, in the units printed
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OV_TIMEOUT_MS = 50;
    localparam int RESTART_MS = 1000;
    localparam int CROWBAR_MS = 1;
    localparam int TRIP_DELAY_MS = 1;
    localparam int HYST_CODES = 8;
    // external reference scaling: 2.5 over 2.56 is 125 over 128
    localparam logic [16:0] EXT_SCALE_MUL = 17'h0_007d;
    localparam int EXT_SCALE_SHIFT = 7;
    localparam int GROUPS_MAX = 4;
    // supervisor states
    typedef enum logic [7:0] {
        S_RUN = 8'h01,
        S_UV = 8'h02,
        S_PROG = 8'h04,
        S_OV1 = 8'h08,
        S_OV2 = 8'h10,
        S_CB = 8'h20,
        S_HOLD = 8'h40,
        S_RESTART = 8'h80
    } bvs_state_e;
endpackage : bvs_pkg

// File: rtl/bvs_top.sv
// bus voltage supervisor with group fault propagation, apb registers
// What this block does
// - sample bus level with ten-bit converter continuously
// - compare every sample to low, high thresholds
// - symmetric fixed hysteresis around both thresholds
// - below low minus hysteresis: pull fault lines
// - undervoltage clears programming status, saves runtime
// - readable bus-low and bus-high status flags
// - recovery reprograms, then auto or host turn-on
// - above high plus hysteresis: pull lines, save
// - overvoltage past timeout: front end off, clear
// - further timeout: one fixed crowbar pulse
// - one second after recovery: restart front end
// - about one millisecond trip delay
// - select internal or external reference, rescale
// - reference change applies after reset only
// - up to four groups of converters
// - propagate falling group line within ten microseconds
// - errors may kill front end, fire crowbar
// - per aux bit blocks fault to enable
// - aux status never pulls group lines
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module bvs_top
    import bvs_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES,
    parameter int GROUPS = GROUPS_MAX,
    parameter int HYST = HYST_CODES,
    parameter int OV_MS = OV_TIMEOUT_MS,
    parameter int RESTART_DLY_MS = RESTART_MS,
    parameter int CB_MS = CROWBAR_MS,
    parameter int TRIP_MS = TRIP_DELAY_MS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter result
    input wire logic [9:0] adc_data,
    input wire logic adc_valid,
    // group fault lines, open drain
    input wire logic [3:0] ok_in,
    output logic [3:0] ok_out,
    output logic [3:0] ok_oe,
    // converter error lines, low active
    input wire logic [3:0] err_in_n,
    // front end and crowbar
    output logic front_end_enable,
    output logic crowbar_trigger,
    // host reset pin
    input wire logic host_hardware_reset_n,
    // programming and run-time storage handshakes
    output logic reprogram_req,
    input wire logic reprogram_done,
    input wire logic [31:0] prog_ok_set,
    output logic turn_on_req,
    output logic runtime_save_req,
    // auxiliary devices
    output logic [3:0] aux_enable,
    input wire logic [3:0] aux_power_good
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int CBW = $clog2(CB_MS * TICK_CYCLES + 1);
    localparam logic [3:0] GRP_MASK = 4'((1 << GROUPS) - 1);
    bvs_state_e st_q, st_d;
    logic [12:0] sy1_q, sy2_q;
    logic hrst_prev_q, ref_ld_q, ref_act_q;
    logic [3:0] err_prev_q;
    logic [9:0] level_q, low_thr_q, high_thr_q;
    logic [2:0] ctrl_q;
    logic [23:0] prop_q;
    logic [15:0] aux_q;
    logic bus_low_q, bus_high_q, fe_q;
    logic [31:0] prog_q, prdata_q;
    logic [TW-1:0] tick_q;
    logic [11:0] tmr_q, qual_q;
    logic [CBW-1:0] errcb_q;
    logic [3:0] ok_oe_q, aux_en_q;
    logic req_q, on_q, save_q;
    // pin inputs after the second flop
    logic [3:0] ok_low, err_low, aux_pg;
    logic hrst_s;
    assign ok_low = ~sy2_q[3:0] & GRP_MASK;
    assign err_low = ~sy2_q[7:4] & GRP_MASK;
    assign aux_pg = sy2_q[11:8];
    assign hrst_s = sy2_q[12];
    // two flop synchroniser for every pin input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sy1_q <= 13'h1fff;
            sy2_q <= 13'h1fff;
        end
        else
        begin
            sy1_q <= {host_hardware_reset_n, aux_power_good, err_in_n, ok_in};
            sy2_q <= sy1_q;
        end
    end
    // apb decode
    logic setup, wr_en, hit;
    logic wr_ctrl, wr_low, wr_high, wr_stat, wr_prop, wr_aux;
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite;
    assign hit = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
    assign wr_ctrl = wr_en && paddr == CTRL_OFS;
    assign wr_low = wr_en && paddr == LOW_THR_OFS;
    assign wr_high = wr_en && paddr == HIGH_THR_OFS;
    assign wr_stat = wr_en && paddr == STATUS_OFS;
    assign wr_prop = wr_en && paddr == PROP_OFS;
    assign wr_aux = wr_en && paddr == AUX_OFS;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_q;
    // comparisons on the latest sample, widened to avoid wrap
    logic [16:0] lvl_mul;
    logic [10:0] lv, lo, hi, hy;
    logic uv_cond, above_low, ov_cond, below_high;
    assign lvl_mul = {7'h00, level_q} * EXT_SCALE_MUL;
    // external reference reads 125/128 of the internal code scale
    assign lv = {1'b0, ref_act_q ? lvl_mul[EXT_SCALE_SHIFT +: 10] : level_q};
    assign lo = {1'b0, low_thr_q};
    assign hi = {1'b0, high_thr_q};
    assign hy = 11'(HYST);
    assign uv_cond = (lv + hy) < lo;
    assign above_low = lv > (lo + hy);
    assign ov_cond = lv > (hi + hy);
    assign below_high = (lv + hy) < hi;
    // millisecond tick, realigned on every state change
    logic tick, st_chg;
    assign tick = tick_q == TW'(TICK_CYCLES - 1);
    assign st_chg = st_d != st_q;
    logic ov_to, rs_to, cb_to, q_to;
    assign ov_to = tmr_q == 12'(OV_MS);
    assign rs_to = tmr_q == 12'(RESTART_DLY_MS);
    assign cb_to = tmr_q == 12'(CB_MS);
    // one spare tick: the free-running prescaler may tick at once
    assign q_to = qual_q == 12'(TRIP_MS + 1);
    // supervisor sequence
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            S_RUN:
                if (ov_cond && q_to)
                    st_d = S_OV1;
                else if (uv_cond && q_to)
                    st_d = S_UV;
            S_UV:
                if (above_low)
                    st_d = S_PROG;
            S_PROG:
                if (uv_cond)
                    st_d = S_UV;
                else if (reprogram_done)
                    st_d = S_RUN;
            S_OV1:
                if (below_high)
                    st_d = S_RESTART;
                else if (ov_to)
                    st_d = S_OV2;
            S_OV2:
                if (below_high)
                    st_d = S_RESTART;
                else if (ov_to)
                    st_d = S_CB;
            S_CB:
                if (cb_to)
                    st_d = S_HOLD;
            S_HOLD:
                if (below_high)
                    st_d = S_RESTART;
            S_RESTART:
                if (ov_cond)
                    st_d = S_OV1;
                else if (rs_to)
                    st_d = S_PROG;
        endcase
    end
    // events taken on state entry
    logic enter_uv, enter_ov1, enter_ov2, enter_prog, leave_rst, go_run;
    assign enter_uv = st_chg && st_d == S_UV;
    assign enter_ov1 = st_chg && st_d == S_OV1;
    assign enter_ov2 = st_chg && st_d == S_OV2;
    assign enter_prog = st_chg && st_d == S_PROG;
    assign leave_rst = st_chg && st_q == S_RESTART && st_d == S_PROG;
    assign go_run = st_chg && st_d == S_RUN;
    // state, timers and trip qualifier
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= S_UV;
            tick_q <= '0;
            tmr_q <= 12'h000;
            qual_q <= 12'h000;
        end
        else
        begin
            st_q <= st_d;
            tick_q <= (st_chg || tick) ? '0 : tick_q + 1'b1;
            tmr_q <= st_chg ? 12'h000 : tmr_q + {11'h000, tick};
            // the condition must hold a full delay before tripping
            qual_q <= (st_q != S_RUN || !(uv_cond || ov_cond)) ? 12'h000 :
                (q_to ? qual_q : qual_q + {11'h000, tick});
        end
    end
    // sample latch and status flags; a new event beats a clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            level_q <= 10'h000;
            bus_low_q <= 1'b0;
            bus_high_q <= 1'b0;
            fe_q <= 1'b1;
        end
        else
        begin
            if (adc_valid)
                level_q <= adc_data;
            bus_low_q <= enter_uv | (bus_low_q & ~(wr_stat & pwdata[ST_BUS_LOW]));
            bus_high_q <= enter_ov2 | (bus_high_q & ~(wr_stat & pwdata[ST_BUS_HIGH]));
            if (enter_ov2)
                fe_q <= 1'b0;
            else if (leave_rst)
                fe_q <= 1'b1;
        end
    end
    // programming status: undervoltage and overvoltage timeout wipe it, set pulses still win
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prog_q <= 32'h0000_0000;
        else
            prog_q <= ((enter_uv || enter_ov2) ? 32'h0000_0000 : prog_q) | prog_ok_set;
    end
    // handshake pulses towards programmer, storage and converters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_q <= 1'b0;
            on_q <= 1'b0;
            save_q <= 1'b0;
        end
        else
        begin
            req_q <= enter_prog;
            on_q <= (go_run && ctrl_q[CTRL_AUTO_ON]) ||
                (wr_ctrl && pwdata[CTRL_TURN_ON] && st_q == S_RUN);
            save_q <= enter_uv | enter_ov1;
        end
    end
    assign reprogram_req = req_q;
    assign turn_on_req = on_q;
    assign runtime_save_req = save_q;
    // reference selection only moves at reset release or host reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_ld_q <= 1'b1;
            ref_act_q <= 1'b0;
            hrst_prev_q <= 1'b1;
        end
        else
        begin
            ref_ld_q <= 1'b0;
            hrst_prev_q <= hrst_s;
            if (ref_ld_q || (hrst_s && !hrst_prev_q))
                ref_act_q <= ctrl_q[CTRL_REF_EXT];
        end
    end
    // inter-group propagation; mutual pairs in the map would latch
    logic [3:0] prop_drv;
    logic sup_drv;
    assign sup_drv = !(st_q == S_RUN || st_q == S_PROG);
    for (genvar t = 0; t < GROUPS_MAX; t++)
    begin : g_prop
        logic [3:0] src;
        for (genvar g = 0; g < GROUPS_MAX; g++)
        begin : g_src
            assign src[g] = prop_q[4 * g + t];
        end
        assign prop_drv[t] = |(ok_low & src);
    end
    // aux enables; aux status never feeds any group line
    for (genvar i = 0; i < 4; i++)
    begin : g_aux
        logic [1:0] grp;
        assign grp = aux_q[AUX_GRP_LSB + 2 * i +: 2];
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                aux_en_q[i] <= 1'b0;
            else
                aux_en_q[i] <= aux_q[i] & ~(ok_low[grp] & ~aux_q[AUX_BLK_LSB + i]);
        end
    end
    assign aux_enable = aux_en_q;
    // group line drivers, registered for a clean pull
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ok_oe_q <= 4'h0;
        else
            ok_oe_q <= ({4{sup_drv}} | prop_drv) & GRP_MASK;
    end
    assign ok_oe = ok_oe_q;
    assign ok_out = 4'h0;
    // error path: front end kill is a level, crowbar a one-shot
    logic err_fe, err_cb;
    assign err_fe = |(err_low & prop_q[PROP_ERR_FE_LSB +: 4]);
    assign err_cb = |(err_low & ~err_prev_q & prop_q[PROP_ERR_CB_LSB +: 4]);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            err_prev_q <= 4'h0;
            errcb_q <= '0;
        end
        else
        begin
            err_prev_q <= err_low;
            if (err_cb)
                errcb_q <= CBW'(CB_MS * TICK_CYCLES);
            else if (errcb_q != '0)
                errcb_q <= errcb_q - 1'b1;
        end
    end
    assign front_end_enable = fe_q & ~err_fe;
    assign crowbar_trigger = (st_q == S_CB) || (errcb_q != '0);
    // software registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RST;
            low_thr_q <= LOW_THR_RST;
            high_thr_q <= HIGH_THR_RST;
            prop_q <= PROP_RST;
            aux_q <= AUX_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= {1'b0, pwdata[CTRL_REF_EXT], pwdata[CTRL_AUTO_ON]};
            if (wr_low)
                low_thr_q <= pwdata[9:0];
            if (wr_high)
                high_thr_q <= pwdata[9:0];
            if (wr_prop)
                prop_q <= pwdata[23:0];
            if (wr_aux)
                aux_q <= pwdata[15:0];
        end
    end
    // read mux, captured in the setup cycle
    logic [31:0] stat_word, rd_word;
    assign stat_word = {8'h00, st_q, aux_pg, ~ok_low, 3'h0, crowbar_trigger,
        front_end_enable, ref_act_q, bus_high_q, bus_low_q};
    assign rd_word = (paddr == CTRL_OFS) ? {29'h0, ctrl_q} :
        (paddr == LOW_THR_OFS) ? {22'h0, low_thr_q} :
        (paddr == HIGH_THR_OFS) ? {22'h0, high_thr_q} :
        (paddr == LEVEL_OFS) ? {22'h0, level_q} :
        (paddr == STATUS_OFS) ? stat_word :
        (paddr == PROG_OFS) ? prog_q :
        (paddr == PROP_OFS) ? {8'h00, prop_q} :
        (paddr == AUX_OFS) ? {16'h0000, aux_q} : 32'h0000_0000;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata_q <= rd_word;
    end
endmodule : bvs_top
`default_nettype wire

// File: bench/bvs_props.sv
// port assertions for the bus supervisor
`timescale 1ns/100ps
`default_nettype none
module bvs_chk
    import bvs_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES,
    parameter int CB_MS = CROWBAR_MS
) (
    // clock, reset and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // supervisor outputs and handshakes
    input wire logic [3:0] ok_out,
    input wire logic [3:0] ok_oe,
    input wire logic crowbar_trigger,
    input wire logic reprogram_done,
    input wire logic turn_on_req,
    input wire logic runtime_save_req
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // access decode, same map as the slave
    wire acc = psel && penable;
    wire hole = (paddr > 8'h1c) || (paddr[1:0] != 2'h0);
    wire ton_wr = acc && pwrite && (paddr == CTRL_OFS) && pwdata[CTRL_TURN_ON];
    // crowbar high time, counted: too long for a repetition
    int cb_run_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cb_run_q <= 0;
        else
            cb_run_q <= crowbar_trigger ? cb_run_q + 1 : 0;
    end
    apb_ready_a: assert property (pready)
        else $error("pready low");
    hole_err_a: assert property (acc && hole |-> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    map_ok_a: assert property (!(acc && hole) |-> !pslverr)
        else $error("error on mapped access");
    line_drive_a: assert property (ok_out == 4'h0)
        else $error("group line driven high");
    cb_max_a: assert property (cb_run_q <= CB_MS * TICK_CYCLES + 1)
        else $error("crowbar pulse too long");
    cb_min_a: assert property ($fell(crowbar_trigger) |-> cb_run_q >= CB_MS * TICK_CYCLES)
        else $error("crowbar pulse too short");
    trip_pull_a: assert property (runtime_save_req |-> ##[0:1] ok_oe == 4'hf)
        else $error("trip without all lines pulled");
    turn_on_src_a: assert property (turn_on_req |-> $past(reprogram_done) ||
        $past(reprogram_done, 2) || $past(ton_wr) || $past(ton_wr, 2))
        else $error("turn-on without cause");
    save_pulse_a: assert property (runtime_save_req |=> !runtime_save_req)
        else $error("save request longer than one cycle");
endmodule : bvs_chk
bind bvs_top bvs_chk #(.TICK_CYCLES(TICK_CYCLES), .CB_MS(CB_MS)) bvs_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ok_out(ok_out), .ok_oe(ok_oe), .crowbar_trigger(crowbar_trigger),
    .reprogram_done(reprogram_done), .turn_on_req(turn_on_req),
    .runtime_save_req(runtime_save_req));
`default_nettype wire

// File: bench/bvs_far_model.sv
// converters, bus converter and group lines on the far side
`timescale 1ns/100ps
`default_nettype none
module bvs_far_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench controls
    input wire logic [9:0] level,
    input wire logic [3:0] fault_pull,
    input wire logic slow,
    // device side
    input wire logic [3:0] ok_oe,
    output logic [3:0] ok_in,
    input wire logic reprogram_req,
    output logic reprogram_done = 1'b0,
    output logic [31:0] prog_ok_set = 32'h0000_0000,
    output logic [9:0] adc_data = 10'h000,
    output logic adc_valid = 1'b0
);
    int smp_q = 0;
    int prg_q = 0;
    // pulled-up wired lines, any party may pull low
    assign ok_in = ~(ok_oe | fault_pull);
    // a sample every eight cycles, garbage on the bus between
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            smp_q <= 0;
            prg_q <= 0;
            adc_valid <= 1'b0;
            reprogram_done <= 1'b0;
            prog_ok_set <= 32'h0000_0000;
        end
        else
        begin
            smp_q <= (smp_q + 1) % 8;
            adc_valid <= (smp_q == 7);
            adc_data <= (smp_q == 7) ? level : ~level;
            prg_q <= reprogram_req ? (slow ? 40 : 4) : (prg_q > 0 ? prg_q - 1 : 0);
            prog_ok_set <= (prg_q == 2) ? 32'h0000_0003 : 32'h0000_0000;
            reprogram_done <= (prg_q == 1);
        end
    end
endmodule : bvs_far_model
`default_nettype wire

// File: bench/bvs_top_tb_top.sv
// self-checking bench for the bus supervisor
`timescale 1ns/100ps
`default_nettype none
module bvs_top_tb_top;
    import bvs_pkg::*;
    localparam int TK = 10;
    localparam int OVM = 3;
    localparam int RSM = 5;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] err_in_n = 4'hf, aux_pg = 4'hf, fault_pull = 4'h0;
    logic hrst_n = 1'b1, slow = 1'b0;
    logic [9:0] level = 10'h000;
    logic [31:0] rdat;
    logic rerr;
    wire [31:0] prdata, prog_ok_set;
    wire [9:0] adc_data;
    wire [3:0] ok_in, ok_out, ok_oe, aux_enable;
    wire pready, pslverr, fe, cb, adc_valid, rp_req, rp_done, ton_req, save_req;
    int fails = 0, cmp_count = 0, cyc = 0, ton_n = 0, save_n = 0, n;
    // short counts so the one-second restart fits the run
    bvs_top #(.TICK_CYCLES(TK), .OV_MS(OVM), .RESTART_DLY_MS(RSM)) bvs_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_data(adc_data), .adc_valid(adc_valid), .ok_in(ok_in), .ok_out(ok_out),
        .ok_oe(ok_oe), .err_in_n(err_in_n), .front_end_enable(fe), .crowbar_trigger(cb),
        .host_hardware_reset_n(hrst_n), .reprogram_req(rp_req), .reprogram_done(rp_done),
        .prog_ok_set(prog_ok_set), .turn_on_req(ton_req), .runtime_save_req(save_req),
        .aux_enable(aux_enable), .aux_power_good(aux_pg));
    bvs_far_model bvs_far_model_inst (
        .pclk(pclk), .presetn(presetn), .level(level), .fault_pull(fault_pull),
        .slow(slow), .ok_oe(ok_oe), .ok_in(ok_in), .reprogram_req(rp_req),
        .reprogram_done(rp_done), .prog_ok_set(prog_ok_set), .adc_data(adc_data),
        .adc_valid(adc_valid));
    always #25 pclk = ~pclk;
    // pulse counters and the hang limit
    always @(posedge pclk)
    begin
        cyc++;
        if (ton_req === 1'b1)
            ton_n++;
        if (save_req === 1'b1)
            save_n++;
        if (cyc == 20000)
        begin
            fails++;
            $display("CHECK FAILED at %0t: timeout", $time);
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat & m, e, "read");
    endtask : rd
    // poll the state field, bounded
    task automatic wst(input bvs_state_e s);
        int k;
        k = 0;
        do
        begin
            apb(1'b0, STATUS_OFS, 32'h0000_0000);
            k++;
        end
        while (rdat[23:16] !== s && k < 200);
        chk(32'(rdat[23:16]), 32'(s), "state");
    endtask : wst
    // cycles until fe (0), crowbar (1) or all lines pulled (2) reach v
    task automatic wsig(input int w, input logic v, output int c);
        c = 0;
        while ((w == 0 ? fe : w == 1 ? cb : &ok_oe) !== v)
        begin
            @(posedge pclk);
            c++;
        end
    endtask : wsig
    task automatic rng(input int c, input int lo, input int hi);
        chk(32'(c >= lo && c <= hi), 32'h0000_0001, "delay");
    endtask : rng
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, read-only level, unmapped hole
        rd(LOW_THR_OFS, 32'hffff_ffff, 32'h0000_0000);
        rd(HIGH_THR_OFS, 32'hffff_ffff, 32'h0000_03ff);
        wr(LEVEL_OFS, 32'h0000_0155);
        rd(LEVEL_OFS, 32'hffff_ffff, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk(32'(rerr), 32'h0000_0001, "hole");
        rd(STATUS_OFS, 32'h00ff_0000, 32'h0002_0000);
        chk(32'(ok_oe), 32'h0000_000f, "lines");
        $display("test reset done");
        // bring-up with auto turn-on
        wr(LOW_THR_OFS, 32'h0000_0064);
        wr(HIGH_THR_OFS, 32'h0000_0320);
        wr(CTRL_OFS, 32'h0000_0001);
        level <= 10'h1f4;
        wst(S_RUN);
        chk(32'(ok_oe), 32'h0000_0000, "lines");
        rd(LEVEL_OFS, 32'hffff_ffff, 32'h0000_01f4);
        rd(PROG_OFS, 32'hffff_ffff, 32'h0000_0003);
        chk(ton_n, 1, "turn-on");
        $display("test bring-up done");
        // undervoltage at the hysteresis edges
        level <= 10'h05f;
        repeat (40) @(posedge pclk);
        rd(STATUS_OFS, 32'h00ff_0000, 32'h0001_0000);
        level <= 10'h05a;
        wsig(2, 1'b1, n);
        rng(n, TK, 2 * TK + 12);
        wst(S_UV);
        rd(STATUS_OFS, 32'h0000_0001, 32'h0000_0001);
        rd(PROG_OFS, 32'hffff_ffff, 32'h0000_0000);
        chk(save_n, 1, "save");
        wr(CTRL_OFS, 32'h0000_0000);
        slow <= 1'b1;
        level <= 10'h069;
        repeat (40) @(posedge pclk);
        rd(STATUS_OFS, 32'h00ff_0000, 32'h0002_0000);
        level <= 10'h06d;
        wst(S_RUN);
        chk(ton_n, 1, "no auto turn-on");
        wr(CTRL_OFS, 32'h0000_0004);
        repeat (3) @(posedge pclk);
        chk(ton_n, 2, "host turn-on");
        wr(CTRL_OFS, 32'h0000_0001);
        slow <= 1'b0;
        $display("test undervoltage done");
        // overvoltage: timeout, front end off, crowbar, restart
        level <= 10'h329;
        wsig(0, 1'b0, n);
        rng(n, (1 + OVM) * TK, (2 + OVM) * TK + 12);
        wsig(1, 1'b1, n);
        rng(n, OVM * TK, OVM * TK + 2);
        rd(STATUS_OFS, 32'h00ff_0002, 32'h0020_0002);
        rd(PROG_OFS, 32'hffff_ffff, 32'h0000_0000);
        chk(save_n, 2, "save");
        wst(S_HOLD);
        level <= 10'h1f4;
        wsig(0, 1'b1, n);
        rng(n, RSM * TK, RSM * TK + 12);
        wst(S_RUN);
        chk(ton_n, 3, "restart turn-on");
        $display("test overvoltage done");
        // group propagation and auxiliary outputs
        wr(PROP_OFS, 32'h0000_0004);
        wr(AUX_OFS, 32'h0000_0023);
        fault_pull <= 4'h1;
        aux_pg <= 4'h0;
        repeat (6) @(posedge pclk);
        chk(32'(ok_oe), 32'h0000_0004, "propagate");
        chk(32'(aux_enable), 32'h0000_0002, "aux block");
        fault_pull <= 4'h0;
        aux_pg <= 4'hf;
        repeat (6) @(posedge pclk);
        chk(32'(ok_oe), 32'h0000_0000, "release");
        chk(32'(aux_enable), 32'h0000_0003, "aux on");
        $display("test propagation done");
        // errors to front end and crowbar
        wr(PROP_OFS, 32'h0021_0000);
        err_in_n <= 4'he;
        repeat (6) @(posedge pclk);
        chk(32'(fe), 32'h0000_0000, "error kill");
        err_in_n <= 4'hd;
        wsig(1, 1'b1, n);
        rng(n, 0, 6);
        err_in_n <= 4'hf;
        wsig(1, 1'b0, n);
        chk(32'(fe), 32'h0000_0001, "kill off");
        $display("test errors done");
        // external reference waits for the host reset pin
        wr(CTRL_OFS, 32'h0000_0003);
        level <= 10'h05c;
        repeat (40) @(posedge pclk);
        rd(STATUS_OFS, 32'h00ff_0004, 32'h0001_0000);
        hrst_n <= 1'b0;
        repeat (3) @(posedge pclk);
        hrst_n <= 1'b1;
        wst(S_UV);
        rd(STATUS_OFS, 32'h0000_0004, 32'h0000_0004);
        $display("test reference done");
        give_verdict();
    end
endmodule : bvs_top_tb_top
`default_nettype wire
